// ===== src/bridge_window_defines.svh
`ifndef BRIDGE_WINDOW_DEFINES_SVH
`define BRIDGE_WINDOW_DEFINES_SVH

// register byte offsets
`define OFS_PF_LOW 8'h24
`define OFS_PF_BASE_UP 8'h28
`define OFS_PF_LIMIT_UP 8'h2c
`define OFS_IO_UP 8'h30
`define OFS_CAP_PTR 8'h34
`define OFS_INT_CTRL 8'h3c
`define OFS_IO_LOW 8'h80
`define OFS_IRQ_STAT 8'h88
`define OFS_IRQ_MASK 8'h8c

// reset and fixed values
`define ZERO32 32'h0000_0000
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define CAP_PTR_VAL 8'h40
`define PF_TYPE_64 4'h1
`define PF_LIMIT_FILL 20'hfffff
`define PF_BASE_FILL 20'h00000
`define IO_LIMIT_FILL 12'hfff
`define IO_BASE_FILL 12'h000

// legacy video ranges
`define VGA_MEM_LO 64'h0000_0000_000a_0000
`define VGA_MEM_HI 64'h0000_0000_000b_ffff
`define VGA_IO_A_LO 10'h3b0
`define VGA_IO_A_HI 10'h3bb
`define VGA_IO_B_LO 10'h3c0
`define VGA_IO_B_HI 10'h3df
`define IO_TOP_ZERO 16'h0000
`define VGA16_ZERO 6'h00
`define ISA_LOW256 2'h0

// field positions
`define CTRL_LSB 16
`define CTRL_MSB 20
`define PIN_LSB 8
`define PIN_MSB 15
`define LINE_MSB 7
`define PF_BLO_LSB 4
`define PF_BLO_MSB 15
`define PF_LLO_LSB 20
`define PF_LLO_MSB 31
`define IO_BLO_LSB 4
`define IO_BLO_MSB 7
`define IO_LLO_LSB 12
`define IO_LLO_MSB 15
`define HALF_MSB 15
`define HALF_HI 16
`define WORD_MSB 31

// bridge control bits within the ctrl field
`define C_PERR 0
`define C_SERR 1
`define C_ISA 2
`define C_VGA 3
`define C_VGA16 4

// interrupt status bits
`define IRQ_POISON 0
`define IRQ_ERRFWD 1
`define IRQ_HOTPLUG 2
`define IRQ_W 3

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== src/bridge_window_pkg.sv
package bridge_window_pkg;

  // address check offered by the forwarding engine
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [63:0] addr;
  } fwd_req_t;

  // forwarding verdict, one cycle after the request
  typedef struct packed {
    logic valid;
    logic pf_hit;
    logic io_down;
    logic io_up;
    logic vga;
  } fwd_ans_t;

  // error message: 0 correctable, 1 non-fatal, 2 fatal
  typedef struct packed {
    logic valid;
    logic [1:0] sev;
  } err_msg_t;

  typedef struct packed {
    logic [31:0] pf_base_up;
    logic [31:0] pf_limit_up;
    logic [11:0] pf_base_lo;
    logic [11:0] pf_limit_lo;
    logic [15:0] io_base_up;
    logic [15:0] io_limit_up;
    logic [3:0] io_base_lo;
    logic [3:0] io_limit_lo;
    logic [7:0] int_line;
    logic [7:0] int_pin;
    logic [4:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
  } cfg_t;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_t;

  typedef struct packed {
    cfg_t cfg;
    bus_t bus;
    fwd_ans_t ans;
    logic poison_report;
    err_msg_t err_fwd;
  } state_t;

endpackage

// ===== src/bridge_window_config_regs.sv
`timescale 1ns/1ps
`include "bridge_window_defines.svh"

// Functional notes
// - prefetch base upper word holds address bits 63:32, writable, resets 0.
// - prefetch limit upper word holds address bits 63:32, writable, resets 0.
// - I/O base upper half sits in bits 15:0, address bits 31:16, resets 0.
// - I/O limit upper half sits in bits 31:16, address bits 31:16, resets 0.
// - capability pointer reads as the power management block offset 40h.
// - interrupt pin byte in bits 15:8 is read-only, resets 0, loader may set.
// - bit 16 set enables detecting and reporting secondary poisoned packets.
// - bit 17 set forwards secondary error messages to the primary side.
// - bit 18 clear forwards every I/O window address downstream.
// - bit 18 set sends window I/O in first 64KB, top 768B per 1KB, upstream.
// - bit 19 set forwards legacy video memory 000A0000h to 000BFFFFh.
// - with bit 19 set, I/O in first 64KB with low ten bits 3B0-3BBh or 3C0-3DFh is video.
// - with bit 19 clear no legacy video memory or I/O is forwarded.
// - prefetch limit low 20 address bits count as all ones.
// - prefetch base and limit type fields read 1h, 64-bit capable.
// - bit 20 picks video I/O decode of 10 bits (0) or 16 bits (1).
module bridge_window_config_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input bridge_window_pkg::fwd_req_t fwd_req,
  output bridge_window_pkg::fwd_ans_t fwd_ans,
  input wire logic poison_in,
  output logic poison_report,
  input bridge_window_pkg::err_msg_t err_msg_in,
  output bridge_window_pkg::err_msg_t err_msg_fwd,
  input wire logic hotplug_event,
  input wire logic pin_load_valid,
  input wire logic [7:0] pin_load_value,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // helpers are pure functions so the read and write paths share one
  // decode; a second copy of the map would drift from the first
  // over time and give reads that disagree with what writes landed
  //
  // byte-lane merge of a write into the current word
  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // register read view; bit 32 flags a mapped offset
  // constant fields come straight from the defines, so software
  // can never disturb the capability pointer or the type nibbles
  // unmapped offsets read zero and answer with an error response
  function automatic logic [32:0] word_at(
    input logic [7:0] a,
    input bridge_window_pkg::cfg_t c
  );
    logic [31:0] w;
    logic hit;
    w = `ZERO32;
    hit = 1'b1;
    if (a == `OFS_PF_LOW) begin
      w = {c.pf_limit_lo, `PF_TYPE_64, c.pf_base_lo, `PF_TYPE_64};
    end else if (a == `OFS_PF_BASE_UP) begin
      w = c.pf_base_up;
    end else if (a == `OFS_PF_LIMIT_UP) begin
      w = c.pf_limit_up;
    end else if (a == `OFS_IO_UP) begin
      w = {c.io_limit_up, c.io_base_up};
    end else if (a == `OFS_CAP_PTR) begin
      w[`LINE_MSB:0] = `CAP_PTR_VAL;
    end else if (a == `OFS_INT_CTRL) begin
      w[`CTRL_MSB:`CTRL_LSB] = c.ctrl;
      w[`PIN_MSB:`PIN_LSB] = c.int_pin;
      w[`LINE_MSB:0] = c.int_line;
    end else if (a == `OFS_IO_LOW) begin
      w[`IO_BLO_MSB:`IO_BLO_LSB] = c.io_base_lo;
      w[`IO_LLO_MSB:`IO_LLO_LSB] = c.io_limit_lo;
    end else if (a == `OFS_IRQ_STAT) begin
      w[`IRQ_W-1:0] = c.irq_stat;
    end else if (a == `OFS_IRQ_MASK) begin
      w[`IRQ_W-1:0] = c.irq_mask;
    end else begin
      hit = 1'b0;
    end
    return {hit, w};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  // whole state in one struct: one comb copy, one register stage
  // keeps every flop under the same synchronous reset
  bridge_window_pkg::state_t st_ff;
  bridge_window_pkg::state_t nxt_st;

  logic [32:0] wr_view;
  logic [32:0] rd_view;
  logic [31:0] wr_word;
  logic [31:0] clr_word;
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic [31:0] io_addr;
  logic [9:0] low10;
  logic io_in_win;
  logic isa_alias;
  logic vga_mem;
  logic vga_io;
  logic [`IRQ_W-1:0] irq_set;

  // window bounds assembled from upper and lower fields
  // base gets zero fill, limit gets ones fill, so a window is never
  // narrower than one granule even when base equals limit
  // both bounds are inclusive; an empty window needs limit < base
  // comparisons run at full width so the upper words take part
  // bounds come from registered fields only, never from bus data
  // in flight, so a half-done write cannot open a stray window
  assign pf_base = {st_ff.cfg.pf_base_up, st_ff.cfg.pf_base_lo,
                    `PF_BASE_FILL};
  assign pf_limit = {st_ff.cfg.pf_limit_up, st_ff.cfg.pf_limit_lo,
                     `PF_LIMIT_FILL};
  assign io_base = {st_ff.cfg.io_base_up, st_ff.cfg.io_base_lo,
                    `IO_BASE_FILL};
  assign io_limit = {st_ff.cfg.io_limit_up, st_ff.cfg.io_limit_lo,
                     `IO_LIMIT_FILL};
  assign io_addr = fwd_req.addr[`WORD_MSB:0];
  assign low10 = io_addr[9:0];

  // I/O window and aliasing checks
  // alias only applies inside the first 64KB; above it the window
  // alone decides the direction
  // the bottom quarter of each 1KB block stays downstream, the rest
  // is turned around, so down and up are mutually exclusive
  assign io_in_win = (io_addr >= io_base) && (io_addr <= io_limit);
  assign isa_alias = st_ff.cfg.ctrl[`C_ISA] &&
                     (io_addr[`WORD_MSB:`HALF_HI] == `IO_TOP_ZERO) &&
                     (io_addr[9:8] != `ISA_LOW256);

  // legacy video decode; 10-bit mode ignores bits 15:10
  // video decode runs beside the windows, not inside them, so a
  // video hit may come with or without a window hit
  // 16-bit mode trades alias coverage for a tighter decode
  assign vga_mem = (fwd_req.addr >= `VGA_MEM_LO) &&
                   (fwd_req.addr <= `VGA_MEM_HI);
  assign vga_io = (io_addr[`WORD_MSB:`HALF_HI] == `IO_TOP_ZERO) &&
                  (!st_ff.cfg.ctrl[`C_VGA16] ||
                   io_addr[`HALF_MSB:10] == `VGA16_ZERO) &&
                  ((low10 >= `VGA_IO_A_LO && low10 <= `VGA_IO_A_HI) ||
                   (low10 >= `VGA_IO_B_LO && low10 <= `VGA_IO_B_HI));

  // read and write views of the register file
  assign wr_view = word_at(st_ff.bus.awaddr, st_ff.cfg);
  assign rd_view = word_at(araddr, st_ff.cfg);
  assign wr_word = merge(wr_view[`WORD_MSB:0], st_ff.bus.wdata,
                         st_ff.bus.wstrb);
  assign clr_word = merge(`ZERO32, st_ff.bus.wdata, st_ff.bus.wstrb);

  // poison and error events gated by their enables; hot-plug always sets
  assign irq_set[`IRQ_POISON] = poison_in && st_ff.cfg.ctrl[`C_PERR];
  assign irq_set[`IRQ_ERRFWD] = err_msg_in.valid &&
                                st_ff.cfg.ctrl[`C_SERR];
  assign irq_set[`IRQ_HOTPLUG] = hotplug_event;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one process builds the whole next state
  // default is hold; each branch below only touches its own fields
  // later assignments in this block win, which fixes priorities:
  // a status clear is written after the plain set and re-applies
  // the set, so an event in the clear cycle is never lost
  always_comb begin
    nxt_st = st_ff;
    // bus handshakes: write address and data taken in either order
    if (awvalid && awready) begin
      nxt_st.bus.aw_held = 1'b1;
      nxt_st.bus.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.bus.w_held = 1'b1;
      nxt_st.bus.wdata = wdata;
      nxt_st.bus.wstrb = wstrb;
    end
    if (st_ff.bus.bvalid && bready) begin
      nxt_st.bus.bvalid = 1'b0;
    end

    // status sets always; a clear in the same cycle loses
    nxt_st.cfg.irq_stat = st_ff.cfg.irq_stat | irq_set;

    // commit once both halves of the write are held
    // holding both halves first costs one cycle of latency but lets
    // the master present address and data in either order
    // readies stay low until the response is taken, so no second
    // write can overtake this one
    if (st_ff.bus.aw_held && st_ff.bus.w_held) begin
      nxt_st.bus.aw_held = 1'b0;
      nxt_st.bus.w_held = 1'b0;
      nxt_st.bus.bvalid = 1'b1;
      nxt_st.bus.bresp = wr_view[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (st_ff.bus.awaddr == `OFS_PF_LOW) begin
        nxt_st.cfg.pf_base_lo = wr_word[`PF_BLO_MSB:`PF_BLO_LSB];
        nxt_st.cfg.pf_limit_lo = wr_word[`PF_LLO_MSB:`PF_LLO_LSB];
      end else if (st_ff.bus.awaddr == `OFS_PF_BASE_UP) begin
        nxt_st.cfg.pf_base_up = wr_word;
      end else if (st_ff.bus.awaddr == `OFS_PF_LIMIT_UP) begin
        nxt_st.cfg.pf_limit_up = wr_word;
      end else if (st_ff.bus.awaddr == `OFS_IO_UP) begin
        nxt_st.cfg.io_base_up = wr_word[`HALF_MSB:0];
        nxt_st.cfg.io_limit_up = wr_word[`WORD_MSB:`HALF_HI];
      end else if (st_ff.bus.awaddr == `OFS_INT_CTRL) begin
        // pin byte stays read-only here
        nxt_st.cfg.int_line = wr_word[`LINE_MSB:0];
        nxt_st.cfg.ctrl = wr_word[`CTRL_MSB:`CTRL_LSB];
      end else if (st_ff.bus.awaddr == `OFS_IO_LOW) begin
        nxt_st.cfg.io_base_lo = wr_word[`IO_BLO_MSB:`IO_BLO_LSB];
        nxt_st.cfg.io_limit_lo = wr_word[`IO_LLO_MSB:`IO_LLO_LSB];
      end else if (st_ff.bus.awaddr == `OFS_IRQ_STAT) begin
        nxt_st.cfg.irq_stat = (st_ff.cfg.irq_stat &
                               ~clr_word[`IRQ_W-1:0]) | irq_set;
      end else if (st_ff.bus.awaddr == `OFS_IRQ_MASK) begin
        nxt_st.cfg.irq_mask = wr_word[`IRQ_W-1:0];
      end
    end

    // read: capture data at the address handshake
    // data is frozen in the response register, so it stands stable
    // while the master stalls even if the register changes meanwhile
    if (st_ff.bus.rvalid && rready) begin
      nxt_st.bus.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.bus.rvalid = 1'b1;
      nxt_st.bus.rdata = rd_view[`WORD_MSB:0];
      nxt_st.bus.rresp = rd_view[32] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // loader replaces the pin default; software cannot
    if (pin_load_valid) begin
      nxt_st.cfg.int_pin = pin_load_value;
    end

    // poisoned packets dropped silently while reporting is off
    nxt_st.poison_report = poison_in && st_ff.cfg.ctrl[`C_PERR];

    // secondary error messages pass up only when enabled
    nxt_st.err_fwd.valid = err_msg_in.valid &&
                           st_ff.cfg.ctrl[`C_SERR];
    nxt_st.err_fwd.sev = err_msg_in.sev;

    // forwarding verdict for the offered address
    nxt_st.ans.valid = fwd_req.valid;
    nxt_st.ans.pf_hit = fwd_req.valid && !fwd_req.is_io &&
                        (fwd_req.addr >= pf_base) &&
                        (fwd_req.addr <= pf_limit);
    nxt_st.ans.io_down = fwd_req.valid && fwd_req.is_io &&
                         io_in_win && !isa_alias;
    nxt_st.ans.io_up = fwd_req.valid && fwd_req.is_io &&
                       io_in_win && isa_alias;
    nxt_st.ans.vga = fwd_req.valid && st_ff.cfg.ctrl[`C_VGA] &&
                     (fwd_req.is_io ? vga_io : vga_mem);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous reset; every field starts cleared
  // all documented resets are zero, so one clear covers them all
  // reset must be held for at least one rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // one write and one read in flight; readies drop while answering
  // readies are combinational from flops only, never from valids,
  // so there is no loop through the master's logic
  // data outputs all come from the state register
  assign awready = !st_ff.bus.aw_held && !st_ff.bus.bvalid;
  assign wready = !st_ff.bus.w_held && !st_ff.bus.bvalid;
  assign arready = !st_ff.bus.rvalid;
  assign bvalid = st_ff.bus.bvalid;
  assign bresp = st_ff.bus.bresp;
  assign rvalid = st_ff.bus.rvalid;
  assign rdata = st_ff.bus.rdata;
  assign rresp = st_ff.bus.rresp;

  // forwarding verdict and event outputs are one-cycle pulses
  // a consumer that misses the cycle misses the event
  assign fwd_ans = st_ff.ans;
  assign poison_report = st_ff.poison_report;
  assign err_msg_fwd = st_ff.err_fwd;

  // level interrupt while any unmasked status bit stands
  // masking only hides the line; status still records the event,
  // so unmasking later raises the interrupt at once
  assign irq = |(st_ff.cfg.irq_stat & st_ff.cfg.irq_mask);

endmodule

// ===== testbench/link_partner_model.sv
`timescale 1ns/1ps
// secondary-side link partner: turns a request code into one-cycle events
// kind 0 idle, 1 poisoned packet, 2 error message, 3 hot-plug
module link_partner_model (
  input wire logic aclk,
  input wire logic [1:0] kind,
  input wire logic [1:0] sev,
  output logic poison_in = 1'h0,
  output bridge_window_pkg::err_msg_t err_msg_in = '0,
  output logic hotplug_event = 1'h0
);
  // severity is inverted unless kind is 2, so a stale copy cannot pass unseen
  always @(posedge aclk) begin
    poison_in <= kind == 2'h1;
    hotplug_event <= kind == 2'h3;
    err_msg_in.valid <= kind == 2'h2;
    err_msg_in.sev <= (kind == 2'h2) ? sev : ~sev;
  end
endmodule

// ===== testbench/bridge_window_checker.sv
`timescale 1ns/1ps
module bridge_window_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input bridge_window_pkg::fwd_req_t fwd_req,
  input bridge_window_pkg::fwd_ans_t fwd_ans,
  input wire logic poison_in,
  input wire logic poison_report,
  input bridge_window_pkg::err_msg_t err_msg_in,
  input bridge_window_pkg::err_msg_t err_msg_fwd
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // forwarding verdicts against the request one cycle earlier
  ans_timing_a: assert property (fwd_req.valid |=> fwd_ans.valid)
    else $error("verdict missing");
  io_exclusive_a: assert property (fwd_ans.io_up |-> !fwd_ans.io_down)
    else $error("io both ways");
  io_alias_a: assert property (fwd_ans.io_up |->
    $past(fwd_req.addr[31:16]) == 16'h0 && $past(fwd_req.addr[9:8]) != 2'h0)
    else $error("alias outside range");
  pf_mem_only_a: assert property (fwd_ans.pf_hit |-> !$past(fwd_req.is_io))
    else $error("pf hit on io");
  vga_mem_range_a: assert property (fwd_ans.vga && !$past(fwd_req.is_io) |->
    $past(fwd_req.addr) inside {[64'ha0000:64'hbffff]})
    else $error("vga mem range");
  vga_io_range_a: assert property (fwd_ans.vga && $past(fwd_req.is_io) |->
    $past(fwd_req.addr[9:0]) inside {[10'h3b0:10'h3bb], [10'h3c0:10'h3df]})
    else $error("vga io range");
  ////////////////////////////////////////////////////////////////////////
  // events only pass through when they were really seen
  poison_gate_a: assert property (poison_report |-> $past(poison_in))
    else $error("spurious poison report");
  err_copy_a: assert property (err_msg_fwd.valid |->
    $past(err_msg_in.valid) && err_msg_fwd.sev == $past(err_msg_in.sev))
    else $error("bad error forward");
  ////////////////////////////////////////////////////////////////////////
  // register bus answers arrive on time and stand until taken
  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  bresp_hold_a: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("rdata dropped");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule
bind bridge_window_config_regs bridge_window_checker chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
  .arready, .rdata, .rvalid, .rready, .fwd_req, .fwd_ans, .poison_in,
  .poison_report, .err_msg_in, .err_msg_fwd);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, pin_load_valid = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, pin_load_value = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, kind = 2'h0, sev = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, poison_in, poison_report;
  logic hotplug_event, irq;
  bridge_window_pkg::fwd_req_t fwd_req = '0;
  bridge_window_pkg::fwd_ans_t fwd_ans;
  bridge_window_pkg::err_msg_t err_msg_in, err_msg_fwd;
  int bad_count = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  bridge_window_config_regs uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fwd_req, .fwd_ans,
    .poison_in, .poison_report, .err_msg_in, .err_msg_fwd, .hotplug_event,
    .pin_load_valid, .pin_load_value, .irq);
  link_partner_model lp (.aclk, .kind, .sev, .poison_in, .err_msg_in,
    .hotplug_event);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // handshakes judged at the rising edge; each channel let go once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic done;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      done = bvalid && bready;
      r = bresp;
    end while (!done);
    bready <= 1'h0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      done = rvalid && rready;
      d = rdata;
      r = rresp;
    end while (!done);
    rready <= 1'h0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // e holds pf_hit, io_down, io_up, vga
  task automatic fw(input logic io, input logic [63:0] a, input logic [3:0] e);
    @(posedge aclk);
    fwd_req <= {1'h1, io, a};
    @(posedge aclk);
    fwd_req <= '0;
    #1;
    chk({27'h0, fwd_ans}, {27'h0, 1'h1, e});
  endtask
  // e holds poison_report, error valid, error severity
  task automatic ev(input logic [1:0] k, input logic [1:0] s,
                    input logic [3:0] e);
    @(posedge aclk);
    kind <= k;
    sev <= s;
    @(posedge aclk);
    kind <= 2'h0;
    @(posedge aclk);
    #1;
    chk({28'h0, poison_report, err_msg_fwd}, {28'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    $display("MISMATCH t=%0t timeout", $time);
    complete_run();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h28, 32'h0, 2'h0);
    rd(8'h2c, 32'h0, 2'h0);
    rd(8'h30, 32'h0, 2'h0);
    rd(8'h34, 32'h40, 2'h0);
    rd(8'h3c, 32'h0, 2'h0);
    rd(8'h24, 32'h0001_0001, 2'h0);
    rd(8'h50, 32'h0, 2'h2);
    wr(8'h50, 32'hffff_ffff, 2'h2);
    wr(8'h34, 32'h0000_00ff, 2'h0);
    rd(8'h34, 32'h40, 2'h0);
    wr(8'h28, 32'h0000_0001, 2'h0);
    rd(8'h28, 32'h0000_0001, 2'h0);
    wr(8'h2c, 32'h0000_0001, 2'h0);
    wr(8'h24, 32'h0010_0000, 2'h0);
    rd(8'h24, 32'h0011_0001, 2'h0);
    fw(1'h0, 64'h1_001f_ffff, 4'h8);
    fw(1'h0, 64'h1_0020_0000, 4'h0);
    fw(1'h0, 64'h1_0000_0000, 4'h8);
    fw(1'h0, 64'h0_ffff_ffff, 4'h0);
    wr(8'h30, 32'h0002_0001, 2'h0);
    rd(8'h30, 32'h0002_0001, 2'h0);
    fw(1'h1, 64'h1_0100, 4'h4);
    fw(1'h1, 64'h2_1000, 4'h0);
    fw(1'h1, 64'h0_ffff, 4'h0);
    wr(8'h30, 32'h0, 2'h0);
    wr(8'h80, 32'h0000_1010, 2'h0);
    fw(1'h1, 64'h1100, 4'h4);
    wr(8'h3c, 32'h0004_ff5a, 2'h0);
    rd(8'h3c, 32'h0004_005a, 2'h0);
    fw(1'h1, 64'h1100, 4'h2);
    fw(1'h1, 64'h1000, 4'h4);
    @(posedge aclk);
    pin_load_valid <= 1'h1;
    pin_load_value <= 8'h01;
    @(posedge aclk);
    pin_load_valid <= 1'h0;
    rd(8'h3c, 32'h0004_015a, 2'h0);
    wr(8'h3c, 32'h0, 2'h0);
    fw(1'h0, 64'ha_0000, 4'h0);
    fw(1'h1, 64'h3b0, 4'h0);
    wr(8'h3c, 32'h0008_0000, 2'h0);
    fw(1'h0, 64'ha_0000, 4'h1);
    fw(1'h0, 64'hb_ffff, 4'h1);
    fw(1'h0, 64'hc_0000, 4'h0);
    fw(1'h1, 64'h3bb, 4'h1);
    fw(1'h1, 64'h3bc, 4'h0);
    fw(1'h1, 64'h3df, 4'h1);
    fw(1'h1, 64'h43c0, 4'h1);
    wr(8'h3c, 32'h0018_0000, 2'h0);
    fw(1'h1, 64'h43c0, 4'h0);
    fw(1'h1, 64'h3c0, 4'h1);
    // severity outside error messages is inverted by the partner, hence the 3 below
    wr(8'h3c, 32'h0, 2'h0);
    wr(8'h8c, 32'h7, 2'h0);
    ev(2'h1, 2'h0, 4'h3);
    ev(2'h2, 2'h2, 4'h2);
    chk({31'h0, irq}, 32'h0);
    wr(8'h3c, 32'h0003_0000, 2'h0);
    ev(2'h1, 2'h0, 4'hb);
    chk({31'h0, irq}, 32'h1);
    rd(8'h88, 32'h1, 2'h0);
    wr(8'h88, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h0);
    for (int s = 0; s < 3; s++) begin
      ev(2'h2, s[1:0], {2'h1, s[1:0]});
    end
    rd(8'h88, 32'h2, 2'h0);
    wr(8'h88, 32'h2, 2'h0);
    wr(8'h8c, 32'h3, 2'h0);
    ev(2'h3, 2'h0, 4'h3);
    chk({31'h0, irq}, 32'h0);
    wr(8'h8c, 32'h4, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(8'h88, 32'h4, 2'h0);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule
